// file: hdl/sirq_consts.svh
`ifndef SIRQ_CONSTS_SVH
`define SIRQ_CONSTS_SVH

// ----------------------------------------------------------------
// Frame map
// ----------------------------------------------------------------
`define SIRQ_DEV_FIRST_FRM 6'h02
`define SIRQ_DEV_LAST_FRM  6'h10
`define SIRQ_HOST_FRAMES   6'h11
`define SIRQ_FRM_MAX       6'h3F
`define SIRQ_CARRY_MASK    16'hFFFE
`define SIRQ_SMI_BIT       4'h2

// ----------------------------------------------------------------
// Pulse widths in clocks
// ----------------------------------------------------------------
`define SIRQ_STOP_QUIET    4'h2
`define SIRQ_STOP_CONT     4'h3
`define SIRQ_HOST_LEN_MIN  3'h3
`define SIRQ_WIDTH_MAX     4'hF

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SIRQ_LVL_RST       16'hFFFF
`define SIRQ_HLVL_RST      17'h1_FFFF

`endif

// file: hdl/sirq_pkg.sv
package sirq_pkg;

	typedef enum logic [3:0] {
		SST_IDLE   = 4'b0001,
		SST_START  = 4'b0010,
		SST_FRAMES = 4'b0100,
		SST_GAP    = 4'b1000
	} sirq_sst_e;

	typedef enum logic [6:0] {
		HST_IDLE   = 7'b000_0001,
		HST_START  = 7'b000_0010,
		HST_HIGH   = 7'b000_0100,
		HST_FRAMES = 7'b000_1000,
		HST_STOP   = 7'b001_0000,
		HST_STOPHI = 7'b010_0000,
		HST_GAP    = 7'b100_0000
	} sirq_hst_e;

	typedef enum logic [2:0] {
		PH_S = 3'b001,
		PH_R = 3'b010,
		PH_T = 3'b100
	} sirq_ph_e;

endpackage : sirq_pkg

// file: hdl/sirq_if.sv
`timescale 1ns/1ns
`default_nettype none

interface sirq_if;
	logic dev_oe;
	logic dev_out;
	logic host_oe;
	logic host_out;
	logic line;

	// Open-drain style wire with pull-up: any low driver wins
	assign line = ~((dev_oe & ~dev_out) | (host_oe & ~host_out));

	modport dev  (output dev_oe, output dev_out, input line);
	modport host (output host_oe, output host_out, input line);
endinterface : sirq_if

`default_nettype wire

// file: hdl/sirq_pulse_meter.sv
`timescale 1ns/1ns
`default_nettype none
`include "sirq_consts.svh"

// Counts consecutive low clocks on the line and flags the rising edge
module sirq_pulse_meter (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	// Line
	input  wire logic       line_i,
	// Measurement
	output logic            rise_o,
	output logic [3:0]      width_o
);
	logic [3:0] cnt_r;

	// Saturates so an abnormal long low never wraps into a stop width
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_r <= 4'h0;
		end else if (!line_i) begin
			cnt_r <= (cnt_r == `SIRQ_WIDTH_MAX) ? cnt_r : cnt_r + 4'h1;
		end else begin
			cnt_r <= 4'h0;
		end
	end

	assign rise_o  = line_i && (cnt_r != 4'h0);
	assign width_o = cnt_r;
endmodule : sirq_pulse_meter

`default_nettype wire

// file: hdl/sirq_slave.sv
`timescale 1ns/1ns
`default_nettype none
`include "sirq_consts.svh"

// How it works
// R01 - Quiet start: one low clock, never high
// R02 - No start while a cycle runs
// R03 - Host extends start low to 4-8 clocks
// R04 - Level change in quiet mode starts cycle
// R05 - Continuous mode: only host starts cycles
// R06 - Mode changes at stop; reset is continuous
// R07 - Measure every stop pulse width
// R08 - Count 3-clock frames from start rise
// R09 - Sample phase: low only if level low
// R10 - Recovery after own low: drive high
// R11 - Turn-around: release the line
// R12 - Drive frames whoever began the cycle
// R13 - Frame n samples 3n-1 clocks after rise
// R14 - Frame n carries line n-1; frame 3 shared
// R15 - Request routed to frame and pin
// R16 - Frame 14 carries line 13
// R17 - Host ends cycle with 2-3 clock stop
// R18 - Stop width 2 quiet, 3 continuous
// R19 - Any idle gap before next start
// R20 - Host runs at least 17 frames
// R21 - Host delays end-of-interrupt by latency
// R22 - Drive and sample on rising clock only
// R23 - Line released during reset; continuous idle
// R24 - Host runs first cycle after reset
module sirq_slave
	import sirq_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// Interrupt levels; bit n rides frame n+1, bit 0 unused
	input  wire logic [15:0] irq_lvl_i,
	// System-management request, low while pending
	input  wire logic        system_mgmt_request_n_i,
	input  wire logic        smi_to_frame_i,
	input  wire logic        smi_to_pin_i,
	// Status
	output logic             quiet_mode_o,
	output logic             cycle_active_o,
	output logic             system_mgmt_irq_out_n_o,
	// Serial link
	sirq_if.dev              link
);

	// ----------------------------------------------------------------
	// Frame decoding
	// ----------------------------------------------------------------
	function automatic logic owns_frame(input logic [5:0] frm);
		owns_frame = (frm >= `SIRQ_DEV_FIRST_FRM) && (frm <= `SIRQ_DEV_LAST_FRM);
	endfunction : owns_frame

	function automatic logic [3:0] frame_idx(input logic [5:0] frm);
		logic [5:0] idx;
		idx = frm - 6'h01;
		frame_idx = idx[3:0];
	endfunction : frame_idx

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	sirq_sst_e   st_r;
	sirq_sst_e   st_nxt;
	sirq_ph_e    ph_r;
	sirq_ph_e    ph_nxt;
	logic [5:0]  frm_r;
	logic [5:0]  frm_nxt;
	logic        quiet_r;
	logic        quiet_nxt;
	logic [15:0] sent_r;
	logic [15:0] sent_nxt;
	logic        oe_r;
	logic        oe_nxt;
	logic        out_r;
	logic        out_nxt;
	logic        smi_pin_r;

	wire logic        line_w;
	wire logic        rise_w;
	wire logic [3:0]  width_w;
	wire logic        smi_act_w;
	wire logic [15:0] eff_lvl_w;
	wire logic        pending_w;
	wire logic        stop_w;

	assign line_w = link.line;

	sirq_pulse_meter sirq_pulse_meter_i (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.line_i  (line_w),
		.rise_o  (rise_w),
		.width_o (width_w)
	);

	// ----------------------------------------------------------------
	// Levels to carry
	// ----------------------------------------------------------------
	// Frame 3 merges line 2 with the request; low from either wins
	assign smi_act_w = ~system_mgmt_request_n_i & smi_to_frame_i; // see R15
	assign eff_lvl_w = irq_lvl_i & ~({15'h0, smi_act_w} << `SIRQ_SMI_BIT); // see R14

	// A level that differs from what was last sent still needs a cycle;
	// a change after its frame passed stays pending for the next one
	assign pending_w = |((eff_lvl_w ^ sent_r) & `SIRQ_CARRY_MASK); // see R04

	// Any low of two clocks or more inside a cycle is the stop pulse
	assign stop_w = rise_w && (width_w >= `SIRQ_STOP_QUIET); // see R07

	// ----------------------------------------------------------------
	// Next state and line drive
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt    = st_r;
		ph_nxt    = ph_r;
		frm_nxt   = frm_r;
		quiet_nxt = quiet_r;
		sent_nxt  = sent_r;
		oe_nxt    = 1'b0;
		out_nxt   = 1'b1;
		case (st_r)
			SST_IDLE: begin
				if (!line_w) begin
					st_nxt = SST_START; // see R12
				end else if (quiet_r && pending_w) begin
					// One low clock, then released; the host holds it on
					st_nxt  = SST_START; // see R01, R02, R04, R05
					oe_nxt  = 1'b1;
					out_nxt = 1'b0;
				end
			end
			SST_START: begin
				if (rise_w) begin
					st_nxt  = SST_FRAMES; // see R08
					ph_nxt  = PH_T;
					frm_nxt = 6'h00;
				end
			end
			SST_FRAMES: begin
				if (stop_w) begin
					st_nxt    = SST_GAP;
					quiet_nxt = (width_w == `SIRQ_STOP_QUIET); // see R06, R18
				end else begin
					case (ph_r)
						PH_T: begin
							ph_nxt = PH_S;
							if (frm_r != `SIRQ_FRM_MAX) begin
								frm_nxt = frm_r + 6'h01; // see R13
							end
						end
						PH_S: ph_nxt = PH_R;
						PH_R: ph_nxt = PH_T;
						default: ph_nxt = PH_T;
					endcase
					if (ph_nxt == PH_S && owns_frame(frm_nxt)) begin
						oe_nxt  = ~eff_lvl_w[frame_idx(frm_nxt)]; // see R09, R16
						out_nxt = 1'b0;
						sent_nxt[frame_idx(frm_nxt)] = eff_lvl_w[frame_idx(frm_nxt)];
					end else if (ph_nxt == PH_R && oe_r && !out_r) begin
						oe_nxt  = 1'b1; // see R10
						out_nxt = 1'b1;
					end
					// Turn-around and foreign frames leave the drive off, see R11
				end
			end
			// Start allowed from the second clock after the stop rise
			SST_GAP: st_nxt = SST_IDLE; // see R18, R19
			default: st_nxt = SST_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r    <= SST_IDLE; // see R23
			ph_r    <= PH_T;
			frm_r   <= 6'h00;
			quiet_r <= 1'b0; // see R06
			sent_r  <= `SIRQ_LVL_RST;
			oe_r    <= 1'b0;
			out_r   <= 1'b1;
		end else begin
			st_r    <= st_nxt; // see R22
			ph_r    <= ph_nxt;
			frm_r   <= frm_nxt;
			quiet_r <= quiet_nxt;
			sent_r  <= sent_nxt;
			oe_r    <= oe_nxt;
			out_r   <= out_nxt;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			smi_pin_r <= 1'b1;
		end else begin
			smi_pin_r <= ~(~system_mgmt_request_n_i & smi_to_pin_i); // see R15
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign link.dev_oe             = oe_r;
	assign link.dev_out            = out_r;
	assign quiet_mode_o            = quiet_r;
	assign cycle_active_o          = (st_r == SST_START) || (st_r == SST_FRAMES);
	assign system_mgmt_irq_out_n_o = smi_pin_r;

endmodule : sirq_slave

`default_nettype wire

// file: hdl/sirq_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "sirq_consts.svh"

module sirq_host
	import sirq_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// Control
	input  wire logic        cycle_req_i,
	input  wire logic        quiet_mode_i,
	input  wire logic [2:0]  start_len_i,
	// Results
	output logic             busy_o,
	output logic             cycle_done_o,
	output logic [16:0]      frame_lvl_o,
	// Serial link
	sirq_if.host             link
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	sirq_hst_e   st_r;
	sirq_hst_e   st_nxt;
	sirq_ph_e    ph_r;
	sirq_ph_e    ph_nxt;
	logic [5:0]  frm_r;
	logic [5:0]  frm_nxt;
	logic [3:0]  cnt_r;
	logic [3:0]  cnt_nxt;
	logic        quiet_r;
	logic        quiet_nxt;
	logic        first_r;
	logic        first_nxt;
	logic        done_r;
	logic        done_nxt;
	logic [16:0] shadow_r;
	logic [16:0] shadow_nxt;
	logic [16:0] lvl_r;
	logic [16:0] lvl_nxt;

	wire logic        line_w;
	wire logic        slave_go_w;
	wire logic [3:0]  len_w;
	wire logic [5:0]  sidx_w;

	assign line_w     = link.line;
	// Slaves may only start in quiet mode; a low in continuous idle is ignored
	assign slave_go_w = quiet_r && !line_w; // see R05, R06
	assign len_w      = {1'b0, (start_len_i < `SIRQ_HOST_LEN_MIN) ? `SIRQ_HOST_LEN_MIN
	                                                               : start_len_i};
	assign sidx_w     = frm_r - 6'h01;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt     = st_r;
		ph_nxt     = ph_r;
		frm_nxt    = frm_r;
		cnt_nxt    = cnt_r;
		quiet_nxt  = quiet_r;
		first_nxt  = first_r;
		done_nxt   = 1'b0;
		shadow_nxt = shadow_r;
		lvl_nxt    = lvl_r;
		case (st_r)
			HST_IDLE: begin
				if (slave_go_w) begin
					st_nxt    = HST_START;
					cnt_nxt   = len_w; // see R03
					first_nxt = 1'b0;
				end else if (first_r || cycle_req_i) begin
					st_nxt    = HST_START;
					cnt_nxt   = len_w + 4'h1; // see R24
					first_nxt = 1'b0;
				end
			end
			HST_START: begin
				if (cnt_r == 4'h1) begin
					st_nxt = HST_HIGH;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			HST_HIGH: begin
				st_nxt  = HST_FRAMES;
				ph_nxt  = PH_T;
				frm_nxt = 6'h00;
			end
			HST_FRAMES: begin
				case (ph_r)
					PH_T: begin
						ph_nxt  = PH_S;
						frm_nxt = frm_r + 6'h01;
					end
					PH_S: begin
						ph_nxt = PH_R;
						shadow_nxt[sidx_w[4:0]] = line_w;
					end
					PH_R: ph_nxt = PH_T;
					default: ph_nxt = PH_T;
				endcase
				if (ph_r == PH_T && frm_r == `SIRQ_HOST_FRAMES) begin // see R17, R20
					st_nxt    = HST_STOP;
					quiet_nxt = quiet_mode_i; // see R18
					cnt_nxt   = quiet_mode_i ? `SIRQ_STOP_QUIET : `SIRQ_STOP_CONT;
					done_nxt  = 1'b1;
					// Published once per cycle, so an end-of-interrupt can wait for done
					lvl_nxt   = shadow_r; // see R21
				end
			end
			HST_STOP: begin
				if (cnt_r == 4'h1) begin
					st_nxt = HST_STOPHI;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			HST_STOPHI: st_nxt = HST_GAP;
			HST_GAP: st_nxt = HST_IDLE;
			default: st_nxt = HST_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r     <= HST_IDLE;
			ph_r     <= PH_T;
			frm_r    <= 6'h00;
			cnt_r    <= 4'h0;
			quiet_r  <= 1'b0;
			first_r  <= 1'b1;
			done_r   <= 1'b0;
			shadow_r <= `SIRQ_HLVL_RST;
			lvl_r    <= `SIRQ_HLVL_RST;
		end else begin
			st_r     <= st_nxt;
			ph_r     <= ph_nxt;
			frm_r    <= frm_nxt;
			cnt_r    <= cnt_nxt;
			quiet_r  <= quiet_nxt;
			first_r  <= first_nxt;
			done_r   <= done_nxt;
			shadow_r <= shadow_nxt;
			lvl_r    <= lvl_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign link.host_oe  = (st_r == HST_START) || (st_r == HST_HIGH) ||
	                       (st_r == HST_STOP) || (st_r == HST_STOPHI);
	assign link.host_out = (st_r == HST_HIGH) || (st_r == HST_STOPHI);
	assign busy_o        = (st_r != HST_IDLE);
	assign cycle_done_o  = done_r;
	assign frame_lvl_o   = lvl_r;

endmodule : sirq_host

`default_nettype wire

// file: sim/sirq_assertions.sv
`timescale 1ns/1ns
`default_nettype none

module sirq_assertions (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic nrst_i,
	// Link signals
	input  wire logic dev_oe,
	input  wire logic dev_out,
	input  wire logic host_oe,
	input  wire logic host_out,
	input  wire logic line
);
	logic [3:0] lcnt_r;
	logic [6:0] kcnt_r;
	logic       qmode_r;
	logic       armed_r = 1'b0;

	// ----------------------------------------
	// Trackers: low run, clock since start rise, mode
	// ----------------------------------------
	wire       dev_lo    = dev_oe & ~dev_out;
	wire       host_hi   = host_oe & host_out;
	wire [3:0] lcnt_nxt  = line ? 4'h0 : lcnt_r + {3'h0, lcnt_r != 4'hF};
	wire [6:0] kcnt_nxt  = (host_hi && lcnt_r > 4'h3) ? 7'h01 : kcnt_r + {6'h0, kcnt_r != 7'h7F};
	wire       qmode_nxt = (host_hi && lcnt_r == 4'h2) | (qmode_r & ~(host_hi && lcnt_r == 4'h3));

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lcnt_r  <= 4'h0;
			kcnt_r  <= 7'h7F;
			qmode_r <= 1'b0;
		end else begin
			lcnt_r  <= lcnt_nxt;
			kcnt_r  <= kcnt_nxt;
			qmode_r <= qmode_nxt;
		end
	end

	// Both ends hold unknowns until the first edge applies their reset
	always_ff @(posedge clk_i) begin
		armed_r <= 1'b1;
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	a_reset_hiz: assert property (disable iff (1'b0)
		armed_r && !nrst_i |-> !dev_oe && !host_oe) else $error("line driven in reset");
	a_high_after_low: assert property (
		dev_oe && dev_out |-> $past(dev_lo)) else $error("slave high without own low");
	a_recovery_high: assert property (
		dev_lo && kcnt_r < 7'd53 |=> dev_oe && dev_out) else $error("no recovery high");
	a_start_release: assert property (
		dev_lo && kcnt_r > 7'd52 |=> !dev_oe) else $error("start low not one clock");
	a_turn_release: assert property (
		dev_lo |-> ##2 !dev_oe) else $error("slave not released at turn-around");
	a_sample_point: assert property (
		dev_lo && kcnt_r < 7'd53 |-> kcnt_r % 3 == 2 && kcnt_r inside {[7'd5:7'd47]})
		else $error("slave low off its sample clock");
	a_start_idle: assert property (
		dev_lo && kcnt_r > 7'd52 |-> qmode_r && $past(line) && $past(line, 2))
		else $error("slave start not allowed here");
	a_start_width: assert property (
		host_hi && kcnt_r > 7'd57 |-> lcnt_r inside {[4'h4:4'h8]}) else $error("start width");
	a_stop_place: assert property (
		host_hi && kcnt_r inside {[7'd1:7'd57]} |-> {3'h0, lcnt_r} + 7'd53 == kcnt_r)
		else $error("stop misplaced");
	a_no_fight: assert property (
		!(dev_oe && host_oe && dev_out != host_out)) else $error("drivers fight");
endmodule : sirq_assertions

`default_nettype wire

// file: sim/serial_irq_slave_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t %h %h", $time, a, b); end end

module serial_irq_slave_bench;
	logic        clk_i   = 1'b0;
	logic        nrst_i  = 1'b0;
	logic [15:0] irq_lvl = 16'hFFFF;
	logic        smi_n   = 1'b1;
	logic        smi_frm = 1'b0;
	logic        smi_pin = 1'b0;
	logic        req     = 1'b0;
	logic        quiet   = 1'b0;
	logic [2:0]  slen    = 3'h3;
	logic        quiet_o;
	logic        smi_pin_n;
	logic        busy;
	logic        act;
	logic        done;
	logic [16:0] flvl;
	logic [15:0] pats [8] = '{16'hFFFD, 16'hFFFB, 16'hDFFF, 16'h7FFF,
		16'h0000, 16'hAAAA, 16'h5555, 16'hFFFE};
	int          fail_count = 0;
	int          n_tests    = 0;

	always #4 clk_i = ~clk_i;

	// ----------------------------------------
	// Both ends and the checker
	// ----------------------------------------
	sirq_if lk ();
	sirq_slave sirq_slave_i (.clk_i(clk_i), .nrst_i(nrst_i), .irq_lvl_i(irq_lvl),
		.system_mgmt_request_n_i(smi_n), .smi_to_frame_i(smi_frm), .smi_to_pin_i(smi_pin),
		.quiet_mode_o(quiet_o), .cycle_active_o(act), .system_mgmt_irq_out_n_o(smi_pin_n),
		.link(lk));
	sirq_host sirq_host_i (.clk_i(clk_i), .nrst_i(nrst_i), .cycle_req_i(req),
		.quiet_mode_i(quiet), .start_len_i(slen), .busy_o(busy), .cycle_done_o(done),
		.frame_lvl_o(flvl), .link(lk));
	sirq_assertions sirq_assertions_i (.clk_i(clk_i), .nrst_i(nrst_i), .dev_oe(lk.dev_oe),
		.dev_out(lk.dev_out), .host_oe(lk.host_oe), .host_out(lk.host_out), .line(lk.line));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic wait_busy(input logic v);
		for (int i = 0; i < 300; i++) begin
			@(negedge clk_i);
			if (busy === v) break;
		end
		`CHK(busy, v)
	endtask : wait_busy

	// Levels must not move before the done pulse that publishes them
	task automatic wait_done();
		logic [16:0] held;
		logic        chg;
		held = flvl;
		chg  = 1'b0;
		for (int i = 0; i < 300; i++) begin
			@(negedge clk_i);
			if (done === 1'b1) break;
			if (flvl !== held) chg = 1'b1;
		end
		`CHK(done, 1'b1)
		`CHK(chg, 1'b0)
	endtask : wait_done

	// Host-begun cycle; frame 1 and frame 17 always read high
	task automatic run(input logic [15:0] lvl, input logic [2:0] len, input logic q);
		logic [16:0] exp;
		wait_busy(1'b0);
		@(posedge clk_i);
		irq_lvl <= lvl;
		slen    <= len;
		quiet   <= q;
		req     <= 1'b1;
		wait_busy(1'b1);
		@(posedge clk_i);
		req <= 1'b0;
		exp = {1'b1, lvl[15:1], 1'b1};
		if (smi_frm && !smi_n) exp[2] = 1'b0;
		wait_done();
		`CHK(act, 1'b1)
		`CHK(flvl, exp)
	endtask : run

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_first();
		@(negedge clk_i);
		`CHK(quiet_o, 1'b0)
		`CHK(smi_pin_n, 1'b1)
		wait_done();
		`CHK(flvl, 17'h1_FFFF)
	endtask : t_first

	task automatic t_levels();
		for (int i = 0; i < 8; i++) begin
			run(pats[i], 3'(i), 1'b0);
		end
	endtask : t_levels

	task automatic t_smi();
		@(posedge clk_i);
		smi_n   <= 1'b0;
		smi_frm <= 1'b1;
		smi_pin <= 1'b1;
		run(16'hFFFF, 3'h3, 1'b0);
		`CHK(smi_pin_n, 1'b0)
		@(posedge clk_i);
		smi_frm <= 1'b0;
		smi_pin <= 1'b0;
		run(16'hFFFF, 3'h3, 1'b0);
		`CHK(smi_pin_n, 1'b1)
		@(posedge clk_i);
		smi_n <= 1'b1;
	endtask : t_smi

	// Quiet stop lets the slave start on a level change; continuous stop forbids it
	task automatic t_quiet();
		logic drv;
		drv = 1'b0;
		run(16'hFFFF, 3'h3, 1'b1);
		wait_busy(1'b0);
		`CHK(quiet_o, 1'b1)
		`CHK(act, 1'b0)
		@(posedge clk_i);
		irq_lvl <= 16'hFFDF;
		wait_done();
		`CHK(flvl, 17'h1_FFDF)
		run(16'hFFDF, 3'h7, 1'b0);
		wait_busy(1'b0);
		`CHK(quiet_o, 1'b0)
		@(posedge clk_i);
		irq_lvl <= 16'hFFFF;
		// The host ignores a low in continuous idle, so watch the slave's own drive
		for (int i = 0; i < 100; i++) begin
			@(negedge clk_i);
			if (lk.dev_oe !== 1'b0) drv = 1'b1;
		end
		`CHK(drv, 1'b0)
		`CHK(busy, 1'b0)
		run(16'hFFFF, 3'h4, 1'b0);
	endtask : t_quiet

	initial begin
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		t_first();
		t_levels();
		t_smi();
		t_quiet();
		report_and_stop();
	end

	// Whole run is near 1,100 clocks; this allows over thirteen times that
	initial begin
		#120000;
		fail_count++;
		report_and_stop();
	end
endmodule : serial_irq_slave_bench

`default_nettype wire
